// ### shared/extirq_pkg.sv
// Constants, register map and carrier types of the external interrupt request logic.
// Assumes one clock, mclk, with every port synchronous to it.
package extirq_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned N_EXT = 2;
  localparam int unsigned N_PINS = 4;
  localparam int unsigned CTL_W = 8;
  localparam int unsigned PRI_LSB = 0;
  localparam int unsigned PRI_W = 2;
  localparam int unsigned MODE_PRI_LSB = 4;
  localparam int unsigned MODE_ALT_LSB = 6;
  localparam int unsigned PIN_PRIMARY_BASE = 2;
  localparam int unsigned WINDOW_CLKS = 8;

  localparam logic [ADDR_W-1:0] OFF_CTL0 = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_CTL1 = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_MASK = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_PEND = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_PORT_OUT = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_PORT_DIR = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_PIN_IN = 5'h1c;

  localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;
  localparam logic [CTL_W-1:0] CTL_PIN4_TOP_BOTH = 8'h33;
  localparam logic [PRI_W-1:0] LVL_OFF = 2'h0;
  localparam logic [PRI_W-1:0] LVL_TOP = 2'h3;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;

  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_RISE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_t;

  typedef enum logic [1:0] {
    SRC_EXT0 = 2'b00,
    SRC_EXT1 = 2'b01,
    SRC_OTHER = 2'b10,
    SRC_NONE = 2'b11
  } src_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

  typedef struct packed {
    logic req;
    src_t src;
    logic [PRI_W-1:0] lvl;
  } int_req_t;

  typedef struct packed {
    logic armed;
    logic prev;
    logic hit;
  } edge_state_t;

  typedef struct packed {
    bus_state_t bus;
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    logic [N_EXT-1:0][CTL_W-1:0] ctl;
    logic [N_EXT-1:0] latch;
    logic [N_EXT-1:0] status;
    logic [N_EXT-1:0] mask;
    logic [N_PINS-1:0] port_out;
    logic [N_PINS-1:0] port_dir;
    int_req_t req;
    logic irq;
  } dev_state_t;

endpackage

// ### src/pin_edge_detect.sv
// Edge detector for one interrupt-capable pin.
// Assumes the pin is already synchronous to mclk.
`timescale 1ns/100ps
module pin_edge_detect (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pin,
  input wire logic [1:0] mode,
  output logic hit
);

  extirq_pkg::edge_state_t st_ff;
  extirq_pkg::edge_state_t nxt_st;
  extirq_pkg::edge_mode_t sel;

  always_comb begin
    sel = extirq_pkg::edge_mode_t'(mode);
    nxt_st = st_ff;
    nxt_st.prev = pin;
    nxt_st.armed = 1'b1;
    // First sample after reset only arms, so a pin high at reset is no edge
    nxt_st.hit = st_ff.armed & (
      ((sel == extirq_pkg::EDGE_RISE || sel == extirq_pkg::EDGE_BOTH) & pin & ~st_ff.prev) |
      ((sel == extirq_pkg::EDGE_FALL || sel == extirq_pkg::EDGE_BOTH) & ~pin & st_ff.prev));
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hit = st_ff.hit;

  chk_edge_polarity: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.armed && pin && !st_ff.prev && sel == extirq_pkg::EDGE_FALL) |=> !st_ff.hit)
    else $error("rising edge hit a falling-only detector");

  chk_edge_rise: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.armed && pin && !st_ff.prev && sel == extirq_pkg::EDGE_RISE) |=> st_ff.hit)
    else $error("rising edge missed by rising detector");

endmodule

// ### src/ext_irq_logic.sv
// External interrupt request logic: edge detectors, request latches, arbitration, registers.
// Assumes an Avalon-MM master, synchronous pins and a processor that pulses take_pulse.
`timescale 1ns/100ps
module ext_irq_logic (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [extirq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [extirq_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [extirq_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [extirq_pkg::N_PINS-1:0] pin_in,
  output logic [extirq_pkg::N_PINS-1:0] pin_out,
  output logic [extirq_pkg::N_PINS-1:0] pin_oe,
  input wire logic other_req,
  input wire logic [extirq_pkg::PRI_W-1:0] other_lvl,
  input wire logic take_pulse,
  input wire extirq_pkg::src_t take_src,
  output extirq_pkg::int_req_t int_out,
  output logic irq
);

  extirq_pkg::dev_state_t st_ff;
  extirq_pkg::dev_state_t nxt_st;
  logic [extirq_pkg::N_PINS-1:0] hit;
  logic [extirq_pkg::N_EXT-1:0] set_ev;
  logic [extirq_pkg::N_EXT-1:0] clr_ev;
  logic [extirq_pkg::N_EXT-1:0] w1c;
  logic wr_now;
  logic [extirq_pkg::PRI_W-1:0] lvl0;
  logic [extirq_pkg::PRI_W-1:0] lvl1;
  logic [extirq_pkg::PRI_W-1:0] lvlo;

  function automatic logic [extirq_pkg::PRI_W-1:0] pri_of(
    input logic [extirq_pkg::CTL_W-1:0] c
  );
    return c[extirq_pkg::PRI_LSB +: extirq_pkg::PRI_W];
  endfunction

  function automatic extirq_pkg::src_t src_of(input int k);
    return (k == 0) ? extirq_pkg::SRC_EXT0 : extirq_pkg::SRC_EXT1;
  endfunction

  // Each request owns one primary pin (four or five) and one alternate pin
  for (genvar k = 0; k < extirq_pkg::N_EXT; k++) begin : g_ext
    pin_edge_detect u_primary (
      .mclk(mclk),
      .rstn(rstn),
      .pin(pin_in[k + extirq_pkg::PIN_PRIMARY_BASE]),
      .mode(st_ff.ctl[k][extirq_pkg::MODE_PRI_LSB +: 2]),
      .hit(hit[k + extirq_pkg::PIN_PRIMARY_BASE])
    );
    pin_edge_detect u_alternate (
      .mclk(mclk),
      .rstn(rstn),
      .pin(pin_in[k]),
      .mode(st_ff.ctl[k][extirq_pkg::MODE_ALT_LSB +: 2]),
      .hit(hit[k])
    );

    // Only this request's own pins set it; no cross term
    assign set_ev[k] = hit[k] | hit[k + extirq_pkg::PIN_PRIMARY_BASE];
    assign clr_ev[k] = take_pulse && (take_src == src_of(k));

    chk_latch_sets: assert property (@(posedge mclk) disable iff (!rstn)
      set_ev[k] |=> st_ff.latch[k])
      else $error("qualified edge did not set its latch");

    chk_take_clears: assert property (@(posedge mclk) disable iff (!rstn)
      (clr_ev[k] && !set_ev[k]) |=> !st_ff.latch[k])
      else $error("taken request left its latch set");

    chk_other_keeps: assert property (@(posedge mclk) disable iff (!rstn)
      (st_ff.latch[k] && take_pulse && take_src != src_of(k)) |=> st_ff.latch[k])
      else $error("latch lost on another source being taken");

    chk_set_wins: assert property (@(posedge mclk) disable iff (!rstn)
      (set_ev[k] && clr_ev[k]) |=> st_ff.latch[k])
      else $error("edge lost against take clear");

    chk_no_phantom: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(st_ff.latch[k]) |-> $past(set_ev[k]))
      else $error("latch rose without its own edge");

    chk_hold_window: assert property (@(posedge mclk) disable iff (!rstn)
      (set_ev[k] && !clr_ev[k]) ##1 (!clr_ev[k] [*7]) |=> st_ff.latch[k])
      else $error("latch dropped inside the edge window");
  end

  assign wr_now = (st_ff.bus == extirq_pkg::BUS_ANSWER) && avs_write && avs_byteenable[0];
  assign w1c = wr_now && (avs_address == extirq_pkg::OFF_STATUS) ?
    avs_writedata[extirq_pkg::N_EXT-1:0] : '0;

  always_comb begin
    nxt_st = st_ff;
    lvl0 = extirq_pkg::LVL_OFF;
    lvl1 = extirq_pkg::LVL_OFF;
    lvlo = extirq_pkg::LVL_OFF;

    // Bus: one wait cycle, then the answer; writes land on the answer edge
    case (st_ff.bus)
      extirq_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_st.bus = extirq_pkg::BUS_ANSWER;
          if (avs_address == extirq_pkg::OFF_CTL0) begin
            nxt_st.rdata = {24'h000000, st_ff.ctl[0]};
          end else if (avs_address == extirq_pkg::OFF_CTL1) begin
            nxt_st.rdata = {24'h000000, st_ff.ctl[1]};
          end else if (avs_address == extirq_pkg::OFF_STATUS) begin
            nxt_st.rdata = {30'h00000000, st_ff.status};
          end else if (avs_address == extirq_pkg::OFF_MASK) begin
            nxt_st.rdata = {30'h00000000, st_ff.mask};
          end else if (avs_address == extirq_pkg::OFF_PEND) begin
            nxt_st.rdata = {24'h000000, st_ff.req.lvl, st_ff.req.src, st_ff.req.req,
                            1'b0, st_ff.latch};
          end else if (avs_address == extirq_pkg::OFF_PORT_OUT) begin
            nxt_st.rdata = {28'h0000000, st_ff.port_out};
          end else if (avs_address == extirq_pkg::OFF_PORT_DIR) begin
            nxt_st.rdata = {28'h0000000, st_ff.port_dir};
          end else if (avs_address == extirq_pkg::OFF_PIN_IN) begin
            nxt_st.rdata = {28'h0000000, pin_in};
          end else begin
            nxt_st.rdata = extirq_pkg::RD_ZERO;
          end
        end
      end
      extirq_pkg::BUS_ANSWER: begin
        nxt_st.bus = extirq_pkg::BUS_IDLE;
        if (wr_now) begin
          if (avs_address == extirq_pkg::OFF_CTL0) begin
            nxt_st.ctl[0] = avs_writedata[extirq_pkg::CTL_W-1:0];
          end else if (avs_address == extirq_pkg::OFF_CTL1) begin
            nxt_st.ctl[1] = avs_writedata[extirq_pkg::CTL_W-1:0];
          end else if (avs_address == extirq_pkg::OFF_MASK) begin
            nxt_st.mask = avs_writedata[extirq_pkg::N_EXT-1:0];
          end else if (avs_address == extirq_pkg::OFF_PORT_OUT) begin
            nxt_st.port_out = avs_writedata[extirq_pkg::N_PINS-1:0];
          end else if (avs_address == extirq_pkg::OFF_PORT_DIR) begin
            nxt_st.port_dir = avs_writedata[extirq_pkg::N_PINS-1:0];
          end
        end
      end
      default: begin
        nxt_st.bus = extirq_pkg::BUS_IDLE;
      end
    endcase
    nxt_st.waitreq = (nxt_st.bus != extirq_pkg::BUS_ANSWER);

    // Latch: set beats clear; only a take of this very source clears it
    nxt_st.latch = set_ev | (st_ff.latch & ~clr_ev);
    nxt_st.status = set_ev | (st_ff.status & ~w1c);
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);

    // Arbitrate on next latch values so a taken request drops at once
    if (nxt_st.latch[0]) begin
      lvl0 = pri_of(nxt_st.ctl[0]);
    end
    if (nxt_st.latch[1]) begin
      lvl1 = pri_of(nxt_st.ctl[1]);
    end
    if (other_req) begin
      lvlo = other_lvl;
    end
    nxt_st.req.req = 1'b1;
    if (lvl1 != extirq_pkg::LVL_OFF && lvl1 >= lvl0 && lvl1 >= lvlo) begin
      nxt_st.req.src = extirq_pkg::SRC_EXT1;
      nxt_st.req.lvl = lvl1;
    end else if (lvl0 != extirq_pkg::LVL_OFF && lvl0 >= lvlo) begin
      nxt_st.req.src = extirq_pkg::SRC_EXT0;
      nxt_st.req.lvl = lvl0;
    end else if (lvlo != extirq_pkg::LVL_OFF) begin
      nxt_st.req.src = extirq_pkg::SRC_OTHER;
      nxt_st.req.lvl = lvlo;
    end else begin
      nxt_st.req.req = 1'b0;
      nxt_st.req.src = extirq_pkg::SRC_NONE;
      nxt_st.req.lvl = extirq_pkg::LVL_OFF;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff.bus <= extirq_pkg::BUS_IDLE;
      st_ff.waitreq <= 1'b1;
      st_ff.rdata <= extirq_pkg::RD_ZERO;
      st_ff.ctl <= {extirq_pkg::N_EXT{extirq_pkg::CTL_RESET}};
      st_ff.latch <= '0;
      st_ff.status <= '0;
      st_ff.mask <= '0;
      st_ff.port_out <= '0;
      st_ff.port_dir <= '0;
      st_ff.req <= {1'b0, extirq_pkg::SRC_NONE, extirq_pkg::LVL_OFF};
      st_ff.irq <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitreq;
  assign pin_out = st_ff.port_out;
  assign pin_oe = st_ff.port_dir;
  assign int_out = st_ff.req;
  assign irq = st_ff.irq;

  chk_tie_order: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.latch == 2'b11 && pri_of(st_ff.ctl[0]) == extirq_pkg::LVL_TOP &&
     pri_of(st_ff.ctl[1]) == extirq_pkg::LVL_TOP) |-> st_ff.req.src == extirq_pkg::SRC_EXT1)
    else $error("equal level tie not won by external one");

  chk_level_taken: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.req.src == extirq_pkg::SRC_EXT0) |->
      (st_ff.req.req && st_ff.latch[0] && st_ff.req.lvl == pri_of(st_ff.ctl[0])))
    else $error("external zero presented at wrong level");

  chk_code_33: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.ctl[0] == extirq_pkg::CTL_PIN4_TOP_BOTH) |->
      (pri_of(st_ff.ctl[0]) == extirq_pkg::LVL_TOP &&
       st_ff.ctl[0][extirq_pkg::MODE_PRI_LSB +: 2] == extirq_pkg::EDGE_BOTH))
    else $error("code 33 hex not decoded as pin four, level three, both edges");

  chk_wait_answer: assert property (@(posedge mclk) disable iff (!rstn)
    (avs_read && avs_waitrequest) |=> !avs_waitrequest)
    else $error("read not answered after one wait cycle");

  chk_irq_gate: assert property (@(posedge mclk) disable iff (!rstn)
    irq |-> |(st_ff.status & st_ff.mask))
    else $error("interrupt high with no unmasked status bit");

endmodule

// ### dv/pin_source.sv
// Model of the signal sources wired to the four interrupt-capable pins.
// Assumes the bench changes src_lvl just after a rising mclk edge.
`timescale 1ns/100ps
module pin_source (
  input wire logic [3:0] src_lvl,
  input wire logic tie,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_in
);
  logic [3:0] ext;
  always_comb begin
    ext = src_lvl;
    // Tied inputs: both request pins see the same source
    if (tie) begin
      ext[3] = src_lvl[2];
    end
    // The device wins the wire while it drives it
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext[i];
    end
  end
endmodule

// ### dv/external_interrupt_request_logic_test.sv
// Self-checking bench for the external interrupt request logic.
// Assumes the design package is compiled first and pin_source models the pin drivers.
`timescale 1ns/100ps
module external_interrupt_request_logic_test;
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] src_lvl = 4'h0;
  logic [3:0] pin_in;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic tie = 1'h0;
  logic other_req = 1'h0;
  logic [1:0] other_lvl = 2'h0;
  logic take_pulse = 1'h0;
  extirq_pkg::src_t take_src = extirq_pkg::SRC_NONE;
  extirq_pkg::int_req_t int_out;
  logic irq;
  logic [31:0] rd;
  logic [3:0] v;
  logic [1:0] l0, l1, lo;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  always #2 mclk = ~mclk;

  ext_irq_logic dut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .other_req(other_req), .other_lvl(other_lvl), .take_pulse(take_pulse),
    .take_src(take_src), .int_out(int_out), .irq(irq));

  pin_source src (.src_lvl(src_lvl), .tie(tie), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));

  task automatic summarize;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count = check_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_req(input extirq_pkg::int_req_t exp);
    check_count = check_count + 1;
    if (int_out !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t request got %h exp %h", $time, int_out, exp);
    end
  endtask

  // Winner as the arbiter should pick it; a zero level means no request
  function automatic extirq_pkg::int_req_t arb(logic [1:0] e0, logic [1:0] e1, logic [1:0] ot);
    arb = '{1'h0, extirq_pkg::SRC_NONE, 2'h0};
    if (ot != 2'h0) arb = '{1'h1, extirq_pkg::SRC_OTHER, ot};
    if (e0 != 2'h0 && e0 >= arb.lvl) arb = '{1'h1, extirq_pkg::SRC_EXT0, e0};
    if (e1 != 2'h0 && e1 >= arb.lvl) arb = '{1'h1, extirq_pkg::SRC_EXT1, e1};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic peek(input logic [4:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk_word(rd, exp, "read");
  endtask

  // Toggle source levels, then leave time for detect and latch
  task automatic flip(input logic [3:0] m);
    @(posedge mclk);
    src_lvl <= src_lvl ^ m;
    tick(3);
  endtask

  task automatic take(input extirq_pkg::src_t s);
    @(posedge mclk);
    take_pulse <= 1'h1;
    take_src <= s;
    @(posedge mclk);
    take_pulse <= 1'h0;
    take_src <= extirq_pkg::SRC_NONE;
    tick(1);
  endtask

  initial begin
    void'($urandom(32'hc48b));
    tick(4);
    rstn <= 1'h1;
    chk_req(arb(2'h0, 2'h0, 2'h0));
    chk_word({31'h0, avs_waitrequest}, 32'h1, "idle wait");
    peek(extirq_pkg::OFF_CTL0, 32'h0);
    peek(extirq_pkg::OFF_CTL1, 32'h0);
    peek(extirq_pkg::OFF_MASK, 32'h0);
    peek(5'h01, 32'h0);
    v = 4'($urandom_range(0, 15));
    bus(1'h1, extirq_pkg::OFF_PORT_OUT, {28'h0, v});
    bus(1'h1, extirq_pkg::OFF_PORT_DIR, 32'hf);
    // Write lands on the answer edge; look one edge later
    tick(1);
    chk_word({24'h0, pin_oe, pin_out}, {24'h0, 4'hf, v}, "port");
    peek(extirq_pkg::OFF_PIN_IN, {28'h0, v});
    bus(1'h1, extirq_pkg::OFF_PORT_DIR, 32'h0);
    peek(extirq_pkg::OFF_PIN_IN, 32'h0);
    bus(1'h1, extirq_pkg::OFF_CTL0, 32'h33);
    flip(4'h4);
    chk_req(arb(2'h3, 2'h0, 2'h0));
    chk_word({31'h0, irq}, 32'h0, "masked irq");
    peek(extirq_pkg::OFF_STATUS, 32'h1);
    bus(1'h1, extirq_pkg::OFF_MASK, 32'h3);
    tick(1);
    chk_word({31'h0, irq}, 32'h1, "irq");
    take(extirq_pkg::SRC_EXT0);
    peek(extirq_pkg::OFF_PEND, 32'h30);
    bus(1'h1, extirq_pkg::OFF_STATUS, 32'h1);
    tick(1);
    chk_word({31'h0, irq}, 32'h0, "irq clr");
    flip(4'h4);
    peek(extirq_pkg::OFF_PEND, 32'hc9);
    take(extirq_pkg::SRC_EXT0);
    flip(4'h4);
    take(extirq_pkg::SRC_OTHER);
    chk_req(arb(2'h3, 2'h0, 2'h0));
    bus(1'h1, extirq_pkg::OFF_CTL0, 32'h31);
    @(posedge mclk);
    other_req <= 1'h1;
    other_lvl <= 2'h3;
    tick(2);
    chk_req(arb(2'h1, 2'h0, 2'h3));
    take(extirq_pkg::SRC_EXT0);
    chk_req(arb(2'h0, 2'h0, 2'h3));
    peek(extirq_pkg::OFF_PEND, 32'he8);
    other_req <= 1'h0;
    flip(4'h4);
    // New edge lands on the take edge
    src_lvl <= src_lvl ^ 4'h4;
    @(posedge mclk);
    take_pulse <= 1'h1;
    take_src <= extirq_pkg::SRC_EXT0;
    @(posedge mclk);
    take_pulse <= 1'h0;
    tick(1);
    chk_req(arb(2'h1, 2'h0, 2'h0));
    take(extirq_pkg::SRC_EXT0);
    bus(1'h1, extirq_pkg::OFF_CTL0, 32'h0);
    bus(1'h1, extirq_pkg::OFF_CTL1, 32'h21);
    flip(4'h8);
    peek(extirq_pkg::OFF_PEND, 32'h5a);
    take(extirq_pkg::SRC_EXT1);
    flip(4'h8);
    chk_req(arb(2'h0, 2'h0, 2'h0));
    bus(1'h1, extirq_pkg::OFF_CTL1, 32'h81);
    flip(4'h2);
    chk_req(arb(2'h0, 2'h1, 2'h0));
    take(extirq_pkg::SRC_EXT1);
    avs_byteenable <= 4'he;
    bus(1'h1, extirq_pkg::OFF_CTL1, 32'h0);
    avs_byteenable <= 4'hf;
    peek(extirq_pkg::OFF_CTL1, 32'h81);
    tie <= 1'h1;
    bus(1'h1, extirq_pkg::OFF_CTL0, 32'h33);
    bus(1'h1, extirq_pkg::OFF_CTL1, 32'h33);
    flip(4'h4);
    chk_req(arb(2'h3, 2'h3, 2'h0));
    take(extirq_pkg::SRC_EXT1);
    chk_req(arb(2'h3, 2'h0, 2'h0));
    take(extirq_pkg::SRC_EXT0);
    bus(1'h1, extirq_pkg::OFF_CTL1, 32'h0);
    tie <= 1'h0;
    for (int i = 0; i < 10; i++) begin
      l0 = 2'($urandom_range(0, 3));
      l1 = 2'($urandom_range(0, 3));
      lo = 2'($urandom_range(0, 3));
      bus(1'h1, extirq_pkg::OFF_CTL0, {24'h0, 6'h0c, l0});
      bus(1'h1, extirq_pkg::OFF_CTL1, {24'h0, 6'h0c, l1});
      other_req <= (lo != 2'h0);
      other_lvl <= lo;
      flip(4'hc);
      chk_req(arb(l0, l1, lo));
      take(extirq_pkg::SRC_EXT0);
      take(extirq_pkg::SRC_EXT1);
      chk_req(arb(2'h0, 2'h0, lo));
    end
    summarize();
  end
endmodule
